//--- rtl/tws_consts.svh
// constants for the three-wire control shift register
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define TWS_WORD_BITS        48
`define TWS_BYTE_BITS        8
`define TWS_BYTE_COUNT       6
`define TWS_COUNT_BITS       6
`define TWS_LAST_BIT_INDEX   6'h2F
`define TWS_BAND_POS         44
`define TWS_PHASE_POS        32
`define TWS_INPEAK_POS       24
`define TWS_RANGE_POS        16
`define TWS_PEAK_TWO_POS     8
`define TWS_PEAK_ONE_POS     0

// ----------------------------------------------------------------
// fields of the band and pump byte
// ----------------------------------------------------------------
`define TWS_VCO_SEL_POS      5
`define TWS_CP_FINE_POS      2
`define TWS_REF_MODE_POS     1
`define TWS_CP_COARSE_POS    0
`define TWS_VCO_BANDS        6
`define TWS_VCO_OFF_LOW      3'h0
`define TWS_VCO_OFF_HIGH     3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TWS_WORD_RESET       48'h000000000000
`define TWS_BYTE_RESET       8'h00
`define TWS_COUNT_RESET      6'h00
`endif

//--- rtl/tws_pkg.sv
// types shared by the three-wire control shift register
package tws_pkg;
    typedef enum logic [1:0] {
        TWS_IDLE  = 2'b00,
        TWS_SHIFT = 2'b01,
        TWS_LOAD  = 2'b11
    } tws_state_t;

    typedef struct packed {
        logic [2:0] vco_sel;
        logic [1:0] unused;
        logic       cp_fine;
        logic       ref_lvds;
        logic       cp_coarse;
    } tws_band_t;

    typedef struct packed {
        tws_band_t  band;
        logic [7:0] phase;
        logic [7:0] in_peak;
        logic [7:0] range;
        logic [7:0] peak_two;
        logic [7:0] peak_one;
    } tws_ctrl_t;

    typedef struct packed {
        logic [47:0] word;
        logic [5:0]  count;
        logic        monitor;
    } tws_link_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } tws_sync_state_t;
endpackage

//--- rtl/tws_link_if.sv
// carrier between the serial-clock shifter and the control core
`timescale 1ns/100ps
interface tws_link_if;
    logic [47:0] shift_word;
    logic [5:0]  bit_count;

    modport shifter (output shift_word, output bit_count);
    modport core    (input  shift_word, input  bit_count);
endinterface

//--- rtl/tws_sync3.sv
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/100ps
module tws_sync3 (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output logic      level
);
    tws_pkg::tws_sync_state_t st;
    tws_pkg::tws_sync_state_t next_st;

    // first stage feeds only the second
    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3)
        begin
            next_st.level = st.s3;
        end
    end

    // idle level of the enable pin is high
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= 4'hF;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule

//--- rtl/tws_shifter.sv
// serial-clock domain: shift register, bit counter and monitor output
`timescale 1ns/100ps
`include "tws_consts.svh"
module tws_shifter (
    input  wire logic      serial_clock_in,
    input  wire logic      sys_rst,
    input  wire logic      serial_data_in,
    input  wire logic      serial_write_enable,
    output logic           serial_monitor_out,
    tws_link_if.shifter    link
);
    tws_pkg::tws_link_state_t st;
    tws_pkg::tws_link_state_t next_st;

    always_comb
    begin
        next_st = st;
        // shift only while the enable is held low
        if (!serial_write_enable)
        begin
            // first bit ends at the top, so byte 1 bit 7 lands at msb
            next_st.word = {st.word[`TWS_WORD_BITS-2:0],
                            serial_data_in};
            next_st.monitor = st.word[`TWS_WORD_BITS-1];
            if (st.count == `TWS_LAST_BIT_INDEX)
            begin
                next_st.count = `TWS_COUNT_RESET;
            end
            else
            begin
                next_st.count = st.count + 6'h01;
            end
        end
        else
        begin
            // no edges arrive here while the clock stands still, so the
            // core judges each burst against the count of the last load
            next_st.count = st.count;
        end
    end

    always_ff @(posedge serial_clock_in or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= {`TWS_WORD_RESET, `TWS_COUNT_RESET, 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign link.shift_word    = st.word;
    assign link.bit_count     = st.count;
    assign serial_monitor_out = st.monitor;
endmodule

//--- rtl/tws_top.sv
// three-wire control shift register: top and system-clock control core
//
// Overview of operation
// - control settings live in a six-byte register loaded only serially
// - each rising serial clock edge with the enable low takes one data bit and shifts the register
// - shifted data is visible on a dedicated monitor output
// - byte 1 goes first, byte 6 last, each byte msb first
// - byte 1: band select, two spare bits, fine pump, ref mode, coarse
// - bytes 2 to 6: phase, input peak, range, peak two, peak one
// - output peaking bytes linearly set the output buffer follower currents
// - band codes 1 to 6 pick a vco band; 0 and 7 turn it off
// - reference mode bit low selects CML, high selects LVDS
// - coarse and fine pump bits pick one of four pump currents
`timescale 1ns/100ps
`include "tws_consts.svh"
module tws_top (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        serial_clock_in,
    input  wire logic        serial_data_in,
    input  wire logic        serial_write_enable,
    output logic             serial_monitor_out,
    output logic [2:0]       vco_band_sel,
    output logic [5:0]       vco_band_enable,
    output logic             vco_off,
    output logic             ref_lvds_mode,
    output logic             ref_cml_mode,
    output logic             cp_fine,
    output logic             cp_coarse,
    output logic [1:0]       cp_current_level,
    output logic [7:0]       clock_phase_delay,
    output logic [7:0]       input_peaking_code,
    output logic [7:0]       vco_follower_current,
    output logic [7:0]       output_peaking_two,
    output logic [7:0]       output_peaking_one,
    output logic [7:0]       clock_output_buffer_ef1,
    output logic [7:0]       clock_output_buffer_ef2,
    output logic             shift_active,
    output logic             load_done,
    output logic             load_aligned
);
    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    tws_link_if link ();

    tws_shifter u_shifter (
        .serial_clock_in     (serial_clock_in),
        .sys_rst             (sys_rst),
        .serial_data_in      (serial_data_in),
        .serial_write_enable (serial_write_enable),
        .serial_monitor_out  (serial_monitor_out),
        .link                (link.shifter)
    );

    // ------------------------------------------------------------
    // enable crossing
    // ------------------------------------------------------------
    logic enable_level;

    tws_sync3 u_sync_en (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (serial_write_enable),
        .level   (enable_level)
    );

    // ------------------------------------------------------------
    // control core state
    // ------------------------------------------------------------
    typedef struct packed {
        tws_pkg::tws_state_t fsm;
        tws_pkg::tws_ctrl_t  ctrl;
        logic                done;
        logic                aligned;
        logic [5:0]          band_en;
        logic                off;
        logic [1:0]          cp_level;
        logic [5:0]          base;
    } tws_core_t;

    tws_core_t st;
    tws_core_t next_st;
    tws_pkg::tws_ctrl_t captured;
    logic [2:0] next_sel;

    // the word is quiet once the enable is high at the pin, and the
    // filtered level lags the pin by at least three clk_sys edges,
    // so the capture sees a settled word without a second crossing
    assign captured = tws_pkg::tws_ctrl_t'(link.shift_word);

    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        unique case (st.fsm)
            tws_pkg::TWS_IDLE:
            begin
                if (!enable_level)
                begin
                    next_st.fsm = tws_pkg::TWS_SHIFT;
                end
            end
            tws_pkg::TWS_SHIFT:
            begin
                // settings stay put while bits are moving
                if (enable_level)
                begin
                    next_st.fsm = tws_pkg::TWS_LOAD;
                end
            end
            tws_pkg::TWS_LOAD:
            begin
                next_st.ctrl    = captured;
                next_st.done    = 1'b1;
                // a whole burst moves the count by a multiple of 48
                next_st.aligned = (link.bit_count == st.base);
                next_st.base    = link.bit_count;
                next_st.fsm     = tws_pkg::TWS_IDLE;
            end
            default:
            begin
                next_st.fsm = tws_pkg::TWS_IDLE;
            end
        endcase

        // band decode: one-hot for codes 1..6, off otherwise
        next_sel = next_st.ctrl.band.vco_sel;
        next_st.off = (next_sel == `TWS_VCO_OFF_LOW)
                   || (next_sel == `TWS_VCO_OFF_HIGH);
        for (int i = 0; i < `TWS_VCO_BANDS; i++)
        begin
            next_st.band_en[i] = (next_sel == 3'(i + 1));
        end

        // coarse is the heavy step, fine the small one
        next_st.cp_level = {next_st.ctrl.band.cp_coarse,
                            next_st.ctrl.band.cp_fine};
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.fsm      <= tws_pkg::TWS_IDLE;
            st.ctrl     <= tws_pkg::tws_ctrl_t'(`TWS_WORD_RESET);
            st.done     <= 1'b0;
            st.aligned  <= 1'b0;
            st.band_en  <= 6'h00;
            st.off      <= 1'b1;
            st.cp_level <= 2'h0;
            st.base     <= `TWS_COUNT_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------
    assign vco_band_sel         = st.ctrl.band.vco_sel;
    assign vco_band_enable      = st.band_en;
    assign vco_off              = st.off;
    assign ref_lvds_mode        = st.ctrl.band.ref_lvds;
    assign ref_cml_mode         = ~st.ctrl.band.ref_lvds;
    assign cp_fine              = st.ctrl.band.cp_fine;
    assign cp_coarse            = st.ctrl.band.cp_coarse;
    assign cp_current_level     = st.cp_level;
    assign clock_phase_delay    = st.ctrl.phase;
    assign input_peaking_code   = st.ctrl.in_peak;
    assign vco_follower_current = st.ctrl.range;
    assign output_peaking_two   = st.ctrl.peak_two;
    assign output_peaking_one   = st.ctrl.peak_one;
    // linear: follower current code equals the peaking byte
    assign clock_output_buffer_ef1 = st.ctrl.peak_one;
    assign clock_output_buffer_ef2 = st.ctrl.peak_two;
    assign shift_active         = (st.fsm == tws_pkg::TWS_SHIFT);
    assign load_done            = st.done;
    assign load_aligned         = st.aligned;
endmodule

//--- bench/tws_top_assertions.sv
// concurrent checks on the ports of the control shift register top
`timescale 1ns/100ps
module tws_top_checker (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       serial_clock_in,
    input wire logic       serial_data_in,
    input wire logic       serial_write_enable,
    input wire logic       serial_monitor_out,
    input wire logic [2:0] vco_band_sel,
    input wire logic [5:0] vco_band_enable,
    input wire logic       vco_off,
    input wire logic       ref_lvds_mode,
    input wire logic       ref_cml_mode,
    input wire logic       cp_fine,
    input wire logic       cp_coarse,
    input wire logic [1:0] cp_current_level,
    input wire logic [7:0] clock_phase_delay,
    input wire logic [7:0] output_peaking_two,
    input wire logic [7:0] output_peaking_one,
    input wire logic [7:0] clock_output_buffer_ef1,
    input wire logic [7:0] clock_output_buffer_ef2,
    input wire logic       shift_active,
    input wire logic       load_done
);
    // ------------------------------------------------------------
    // mirror of the link word, kept from the pins alone
    // ------------------------------------------------------------
    logic [47:0] mirror;
    logic        gone;
    always_ff @(posedge serial_clock_in or posedge sys_rst)
        if (sys_rst)
            {mirror, gone} <= {48'h000000000000, 1'b0};
        else if (!serial_write_enable)
            {mirror, gone} <= {mirror[46:0], serial_data_in, mirror[47]};
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_rise;
        $rose(serial_write_enable) ##0 shift_active;
    endsequence
    sequence s_load;
        ##[2:10] load_done;
    endsequence
    property p_mon;
        @(posedge serial_clock_in) disable iff (sys_rst)
        !serial_write_enable |=> serial_monitor_out == gone;
    endproperty
    property p_word;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(load_done) |-> {vco_band_sel, cp_fine, ref_lvds_mode,
            cp_coarse, clock_phase_delay, output_peaking_one}
            == {mirror[47:45], mirror[42:32], mirror[7:0]};
    endproperty
    property p_off;
        @(posedge clk_sys) disable iff (sys_rst)
        vco_off == (vco_band_sel == 3'h0 || vco_band_sel == 3'h7);
    endproperty
    property p_band;
        @(posedge clk_sys) disable iff (sys_rst)
        !vco_off |-> vco_band_enable == 6'h01 << (vco_band_sel - 3'h1);
    endproperty
    property p_ref;
        @(posedge clk_sys) disable iff (sys_rst)
        ref_cml_mode != ref_lvds_mode;
    endproperty
    property p_pump;
        @(posedge clk_sys) disable iff (sys_rst)
        cp_current_level == {cp_coarse, cp_fine};
    endproperty
    property p_ef;
        @(posedge clk_sys) disable iff (sys_rst)
        {clock_output_buffer_ef1, clock_output_buffer_ef2}
            == {output_peaking_one, output_peaking_two};
    endproperty
    property p_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        shift_active |=> $stable(clock_phase_delay) && $stable(vco_off);
    endproperty
    property p_pulse;
        @(posedge clk_sys) disable iff (sys_rst)
        load_done |=> !load_done;
    endproperty
    property p_late;
        @(posedge clk_sys) disable iff (sys_rst)
        s_rise |-> s_load;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor bit wrong");
    a_word: assert property (p_word) else $error("loaded word wrong");
    a_off: assert property (p_off) else $error("vco off wrong");
    a_band: assert property (p_band) else $error("band enable wrong");
    a_ref: assert property (p_ref) else $error("ref mode wrong");
    a_pump: assert property (p_pump) else $error("pump level wrong");
    a_ef: assert property (p_ef) else $error("follower code wrong");
    a_hold: assert property (p_hold) else $error("changed in shift");
    a_pulse: assert property (p_pulse) else $error("load pulse long");
    a_late: assert property (p_late) else $error("load missing");
endmodule
bind tws_top tws_top_checker chk (.*);

//--- bench/tws_ctrl_model.sv
// external controller driving the three serial control pins
`timescale 1ns/100ps
module tws_ctrl_model (
    output logic serial_clock_in,
    output logic serial_data_in,
    output logic serial_write_enable
);
    initial
    begin
        serial_clock_in = 1'b0;
        serial_data_in = 1'b0;
        serial_write_enable = 1'b1;
    end
    // clock stands still outside frames; odd lead keeps phase unrelated
    task automatic frame(input logic [55:0] bits, input int n);
        serial_write_enable = 1'b0;
        #97.3;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_in = bits[i];
            #3 serial_clock_in = 1'b1;
            #3 serial_clock_in = 1'b0;
        end
        #3 serial_write_enable = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the control shift register
`timescale 1ns/100ps
module tb;
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic       serial_clock_in, serial_data_in, serial_write_enable;
    logic       serial_monitor_out, vco_off, ref_lvds_mode, ref_cml_mode;
    logic       cp_fine, cp_coarse, shift_active, load_done, load_aligned;
    logic [2:0] vco_band_sel;
    logic [5:0] vco_band_enable;
    logic [1:0] cp_current_level;
    logic [7:0] clock_phase_delay, input_peaking_code, vco_follower_current;
    logic [7:0] output_peaking_two, output_peaking_one;
    logic [7:0] clock_output_buffer_ef1, clock_output_buffer_ef2;
    logic [47:0] w;
    int         mismatches = 0;
    int         checks_done = 0;
    tws_top dut (.*);
    tws_ctrl_model ctl (.*);
    always #10 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        checks_done++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait: a lost load counts as one mismatch
    task automatic wait_load;
        int n;
        n = 0;
        while (load_done !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(n < 40, 1'b1);
    endtask
    task automatic expect_word(input logic [47:0] v);
        logic [5:0] en;
        en = 6'h00;
        if (!(v[47:45] inside {3'h0, 3'h7}))
        begin
            en = 6'h01 << (v[47:45] - 3'h1);
        end
        check({vco_band_sel, 2'b00, cp_fine, ref_lvds_mode, cp_coarse},
            v[47:40] & 8'hE7);
        check({clock_phase_delay, input_peaking_code, vco_follower_current,
            output_peaking_two, output_peaking_one}, v[39:0]);
        check({clock_output_buffer_ef1, clock_output_buffer_ef2},
            {v[7:0], v[15:8]});
        check({vco_off, vco_band_enable}, {en == 6'h00, en});
        check({ref_cml_mode, ref_lvds_mode}, {~v[41], v[41]});
        check(cp_current_level, {v[40], v[42]});
        repeat (8) @(negedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) sys_rst = 1'b0;
        check({vco_off, ref_cml_mode, clock_phase_delay, shift_active}, 11'h600);
        repeat (2) @(negedge clk_sys);
        for (int c = 0; c < 8; c++)
        begin
            w = {3'(c), 2'b11, 3'(7 - c), 40'hA53C96E10F ^ {5{8'(c * 37)}}};
            ctl.frame({8'h00, w}, 48);
            wait_load();
            expect_word(w);
        end
        fork
            ctl.frame({8'h00, ~w}, 48);
            begin
                #240;
                check({shift_active, clock_phase_delay}, {1'b1, w[39:32]});
            end
        join
        wait_load();
        expect_word(~w);
        ctl.frame({6'h00, 2'b10, w}, 50);
        wait_load();
        check(load_aligned, 1'b0);
        expect_word(w);
        ctl.frame({8'h00, 48'hFF00FF00FF00}, 48);
        wait_load();
        check(load_aligned, 1'b1);
        expect_word(48'hFF00FF00FF00);
        final_report();
    end
    initial
    begin
        #200000;
        mismatches++;
        final_report();
    end
endmodule
